// File: verilog/rtp_probe.v
// What this block does
// - each test source is a 23-bit lfsr, fixed polynomial, fixed seed
// - lfsrs reload their seed only on the periodic counter pulse
// - seeds per port a..d are 400010, 26e6ce, 6ea298, 0b1eb7 hex
// - 16-bit test sample built from xor combinations of lfsr bits
// - test enable substitutes generator streams for the input streams
// - bypass ignores converter clocks, uses sample clock divided 1,2,4,8
// - constant option drives the top 16 bits of one shared 18-bit constant on all streams
// - noise enable adds generator noise masked by 16-bit level mask
// - 32-bit interval counter, 8-bit pulse width, 3-bit sync select
// - four 64-entry delay lines, free write counter, offset read pointer
// - each offset count adds one sample period of delay
// - 6-bit offsets double buffered, applied on selected sync event
// - probe enable turns ports c,d into outputs with gain pins, 36 bits
// - probe decimator divides by 17 when set, else passes all samples except during the delay wait after a selected sync
// - decimator aligned by selected sync after a 4-bit delay
// - 4-bit source select and 6-bit signal select for the probe
// - probe clock period is rate field plus one sample clocks for rate fields 1 to 31
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "rtp_defs.vh"
module rtp_probe #(
   parameter SW = 16,
   parameter DEPTH = 64
) (
   // system
   input wire clock,
   input wire reset,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // external syncs, converter strobes and samples
   input wire [7:0] sync_in,
   input wire [3:0] conv_strobe,
   input wire [4*SW-1:0] rx_in,
   // internal signals offered to the probe, 36 bits per source
   input wire [36*9-1:0] probe_src,
   // gain-code pins of ports c and d (low 4 of 7 bits used by the probe)
   input wire [6:0] gain_cd_in,
   output reg [6:0] gain_cd_out,
   output wire gain_cd_oe,
   // ports c and d turned around
   output reg [2*SW-1:0] rx_cd_out,
   output wire rx_cd_oe,
   // processed streams and probe clock
   output reg [4*SW-1:0] rx_out,
   output reg [3:0] rx_valid,
   output reg probe_clk,
   output wire [5:0] probe_sig_sel,
   output wire counter_pulse
);
   reg [31:0] ctrl_ff, noise_ff, const_ff, cnt_ff, cntcfg_ff;
   reg [31:0] dly_ff, dlysel_ff, probe_ff;
   reg [23:0] act_dly_ff;
   reg [31:0] ivl_ff;
   reg [7:0] pw_ff;
   reg run_ff;
   reg [2:0] div_ff;
   reg [22:0] lfsr_ff [0:3];
   reg [SW-1:0] mem [0:4*DEPTH-1];
   reg [5:0] wptr_ff;
   reg [4:0] rate_ff;
   reg [3:0] ddly_ff;
   reg [4:0] dcnt_ff;
   reg dwait_ff;
   integer i;
   integer j;
   integer k;

   // three-bit sync selection: 0 = counter pulse (no sync for the counter's own select), others external
   function sync_pick;
      input [2:0] sel;
      input [7:0] s;
      input p;
      begin
         sync_pick = (sel == 3'd0) ? p : s[sel];
      end
   endfunction

   // lfsr step, taps 23 and 18
   function [22:0] lfsr_step;
      input [22:0] v;
      begin
         lfsr_step = {v[21:0], v[22] ^ v[17]};
      end
   endfunction

   // xor mapping of state to sample
   function [15:0] lfsr_map;
      input [22:0] v;
      begin
         lfsr_map = v[15:0] ^ {v[22:16], v[22:14]};
      end
   endfunction

   function [22:0] seed;
      input [1:0] k;
      begin
         case (k)
            2'd0: seed = `RTP_SEED_A;
            2'd1: seed = `RTP_SEED_B;
            2'd2: seed = `RTP_SEED_C;
            default: seed = `RTP_SEED_D;
         endcase
      end
   endfunction

   wire tst_en = ctrl_ff[`RTP_CTRL_TST];
   wire bypass = ctrl_ff[`RTP_CTRL_BYPASS];
   wire [1:0] rate_sel = ctrl_ff[`RTP_CTRL_RATE+1:`RTP_CTRL_RATE];
   wire const_en = ctrl_ff[`RTP_CTRL_CONST];
   wire noise_en = ctrl_ff[`RTP_CTRL_NOISE];
   wire [15:0] noise_level_mask = noise_ff[15:0];
   wire probe_on = probe_ff[`RTP_PROBE_ON];
   wire probe_decim_by_seventeen = probe_ff[`RTP_PROBE_D17];
   wire [2:0] dec_ssel = probe_ff[`RTP_PROBE_SSEL+2:`RTP_PROBE_SSEL];
   wire [3:0] dec_dly = probe_ff[`RTP_PROBE_DLY+3:`RTP_PROBE_DLY];
   wire [3:0] src_sel = probe_ff[`RTP_PROBE_SRC+3:`RTP_PROBE_SRC];
   wire [4:0] prate = probe_ff[`RTP_PROBE_RATE+4:`RTP_PROBE_RATE];

   assign counter_pulse = (pw_ff != 8'h00);
   assign probe_sig_sel =
      probe_ff[`RTP_PROBE_SIG+5:`RTP_PROBE_SIG];
   assign rx_cd_oe = probe_on;
   assign gain_cd_oe = probe_on;

   // wishbone: one wait state free ack, unmapped reads zero
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i;

   function [31:0] wmerge;
      input [31:0] old;
      input [31:0] d;
      input [3:0] s;
      integer b;
      begin
         wmerge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (s[b]) begin
               wmerge[b*8 +: 8] = d[b*8 +: 8];
            end
         end
      end
   endfunction

   always @(posedge clock) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_ff <= 32'h0000_0000;
         noise_ff <= 32'h0000_0000;
         const_ff <= 32'h0000_0000;
         cnt_ff <= 32'h0000_0000;
         cntcfg_ff <= 32'h0000_0000;
         dly_ff <= 32'h0000_0000;
         dlysel_ff <= 32'h0000_0000;
         probe_ff <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_wr) begin
            case (wb_adr_i)
               `RTP_REG_CTRL: ctrl_ff <= wmerge(ctrl_ff, wb_dat_i, wb_sel_i);
               `RTP_REG_NOISE: noise_ff <= wmerge(noise_ff, wb_dat_i,
                  wb_sel_i);
               `RTP_REG_CONST: const_ff <= wmerge(const_ff, wb_dat_i,
                  wb_sel_i);
               `RTP_REG_CNT: cnt_ff <= wmerge(cnt_ff, wb_dat_i, wb_sel_i);
               `RTP_REG_CNTCFG: cntcfg_ff <= wmerge(cntcfg_ff, wb_dat_i,
                  wb_sel_i);
               `RTP_REG_DLY: dly_ff <= wmerge(dly_ff, wb_dat_i, wb_sel_i);
               `RTP_REG_DLYSEL: dlysel_ff <= wmerge(dlysel_ff, wb_dat_i,
                  wb_sel_i);
               `RTP_REG_PROBE: probe_ff <= wmerge(probe_ff, wb_dat_i,
                  wb_sel_i);
               default: ;
            endcase
         end
         if (wb_req) begin
            case (wb_adr_i)
               `RTP_REG_CTRL: wb_dat_o <= {26'h0, ctrl_ff[5:0]};
               `RTP_REG_NOISE: wb_dat_o <= {16'h0000, noise_ff[15:0]};
               `RTP_REG_CONST: wb_dat_o <= {14'h0, const_ff[17:0]};
               `RTP_REG_CNT: wb_dat_o <= cnt_ff;
               `RTP_REG_CNTCFG: wb_dat_o <= {21'h0, cntcfg_ff[10:0]};
               `RTP_REG_DLY: wb_dat_o <= {8'h00, dly_ff[23:0]};
               `RTP_REG_DLYSEL: wb_dat_o <= {20'h0_0000, dlysel_ff[11:0]};
               `RTP_REG_PROBE: wb_dat_o <= {8'h00, probe_ff[23:0]};
               `RTP_REG_STATUS: wb_dat_o <= {act_dly_ff, 2'b00, wptr_ff};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // periodic counter: restarted by selected sync, pulse at interval end
   wire cnt_sync = sync_pick(cntcfg_ff[10:8], sync_in, 1'b0);
   always @(posedge clock) begin
      if (reset) begin
         ivl_ff <= 32'h0000_0000;
         pw_ff <= 8'h00;
         run_ff <= 1'b0;
      end else begin
         if (pw_ff != 8'h00) begin
            pw_ff <= pw_ff - 8'h01;
         end
         if (cnt_sync) begin
            ivl_ff <= cnt_ff;
            run_ff <= 1'b1;
         end else if (run_ff) begin
            if (ivl_ff == 32'h0000_0000) begin
               ivl_ff <= cnt_ff;
               pw_ff <= (cntcfg_ff[7:0] == 8'h00) ? 8'h01 : cntcfg_ff[7:0];
            end else begin
               ivl_ff <= ivl_ff - 32'h0000_0001;
            end
         end
      end
   end

   // sample strobes: divided sample clock under bypass, else converters
   wire [3:0] div_mask = (4'b0001 << rate_sel) - 4'b0001;
   wire div_tick = ((div_ff & div_mask[2:0]) == 3'b000);
   wire [3:0] smp = bypass ? {4{div_tick}} : conv_strobe;
   always @(posedge clock) begin
      if (reset) begin
         div_ff <= 3'b000;
      end else begin
         div_ff <= div_ff + 3'b001;
      end
   end

   wire gen_active = tst_en | noise_en;
   always @(posedge clock) begin
      if (reset) begin
         for (i = 0; i < 4; i = i + 1) begin
            lfsr_ff[i] <= seed(i[1:0]);
         end
      end else begin
         for (i = 0; i < 4; i = i + 1) begin
            if (counter_pulse) begin
               lfsr_ff[i] <= seed(i[1:0]);
            end else if (gen_active & smp[i]) begin
               lfsr_ff[i] <= lfsr_step(lfsr_ff[i]);
            end
         end
      end
   end

   // source mux, noise add, delay lines
   reg [SW-1:0] src [0:3];
   reg [15:0] gen;
   always @* begin
      for (j = 0; j < 4; j = j + 1) begin
         gen = lfsr_map(lfsr_ff[j]);
         if (const_en) begin
            src[j] = const_ff[17:18-SW];
         end else if (tst_en) begin
            src[j] = gen;
         end else if (noise_en) begin
            // noise wraps rather than saturates, same width as the sample
            src[j] = rx_in[j*SW +: SW]
               + (gen & noise_level_mask);
         end else begin
            src[j] = rx_in[j*SW +: SW];
         end
      end
   end

   wire [5:0] rd_a [0:3];
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_rd
         // minus one: offset 0 gives the previous write, not a full lap
         assign rd_a[g] = wptr_ff - act_dly_ff[g*6 +: 6]
            - 6'h01;
      end
   endgenerate

   always @(posedge clock) begin
      if (reset) begin
         wptr_ff <= 6'h00;
         act_dly_ff <= 24'h00_0000;
         rx_valid <= 4'h0;
         rx_out <= {4*SW{1'b0}};
      end else begin
         if (smp[0]) begin
            wptr_ff <= wptr_ff + 6'h01;
         end
         for (k = 0; k < 4; k = k + 1) begin
            if (sync_pick(dlysel_ff[k*3 +: 3], sync_in, counter_pulse)) begin
               act_dly_ff[k*6 +: 6] <= dly_ff[k*6 +: 6];
            end
            if (smp[k]) begin
               mem[k*DEPTH + wptr_ff] <= src[k];
               rx_out[k*SW +: SW] <= mem[k*DEPTH + rd_a[k]];
            end
         end
         rx_valid <= smp;
      end
   end

   // probe: clock divider, delayed decimator, output capture
   wire dsync = sync_pick(dec_ssel, sync_in, counter_pulse);
   wire ptick = (rate_ff == prate);
   wire [35:0] psel = (src_sel < 4'd9) ? probe_src[src_sel*36 +: 36]
      : 36'h0_0000_0000;
   always @(posedge clock) begin
      if (reset) begin
         rate_ff <= 5'h00;
         probe_clk <= 1'b0;
         ddly_ff <= 4'h0;
         dwait_ff <= 1'b0;
         dcnt_ff <= 5'h00;
         rx_cd_out <= {2*SW{1'b0}};
         gain_cd_out <= 7'h00;
      end else begin
         rate_ff <= ptick ? 5'h00 : rate_ff + 5'h01;
         // 6-bit sum so a rate field of 31 still gives a half-high clock
         probe_clk <= ({1'b0, rate_ff} < (({1'b0, prate} + 6'h01) >> 1))
            ? 1'b1 : 1'b0;
         if (dsync) begin
            ddly_ff <= dec_dly;
            dwait_ff <= 1'b1;
         end else if (dwait_ff & ptick) begin
            if (ddly_ff == 4'h0) begin
               dwait_ff <= 1'b0;
               dcnt_ff <= 5'h00;
            end else begin
               ddly_ff <= ddly_ff - 4'h1;
            end
         end else if (ptick) begin
            dcnt_ff <= (dcnt_ff == `RTP_DECIM_N - 5'h01) ? 5'h00
               : dcnt_ff + 5'h01;
         end
         if (probe_on & ptick & ~dwait_ff &
            (~probe_decim_by_seventeen | (dcnt_ff == 5'h00))) begin
            rx_cd_out <= psel[2*SW-1:0];
            gain_cd_out <= {3'b000, psel[35:32]};
         end
      end
   end
endmodule // rtp_probe

// File: verilog/rtp_defs.vh
`ifndef RTP_DEFS_VH
`define RTP_DEFS_VH
// register byte offsets (word aligned)
`define RTP_REG_CTRL 8'h00
`define RTP_REG_NOISE 8'h04
`define RTP_REG_CONST 8'h08
`define RTP_REG_CNT 8'h0C
`define RTP_REG_CNTCFG 8'h10
`define RTP_REG_DLY 8'h14
`define RTP_REG_DLYSEL 8'h18
`define RTP_REG_PROBE 8'h1C
`define RTP_REG_STATUS 8'h20
// ctrl bit positions
`define RTP_CTRL_TST 0
`define RTP_CTRL_BYPASS 1
`define RTP_CTRL_RATE 2
`define RTP_CTRL_CONST 4
`define RTP_CTRL_NOISE 5
// probe register fields
`define RTP_PROBE_ON 0
`define RTP_PROBE_D17 1
`define RTP_PROBE_SSEL 2
`define RTP_PROBE_DLY 5
`define RTP_PROBE_SRC 9
`define RTP_PROBE_SIG 13
`define RTP_PROBE_RATE 19
// generator seeds
`define RTP_SEED_A 23'h40_0010
`define RTP_SEED_B 23'h26_E6CE
`define RTP_SEED_C 23'h6E_A298
`define RTP_SEED_D 23'h0B_1EB7
`define RTP_DECIM_N 5'h11
`endif

// File: verification/rtp_checker.sv
`timescale 1ns/1ps
`include "rtp_defs.vh"
module rtp_checker (
   // system
   input wire clock,
   input wire reset,
   // bus
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // streams and probe
   input wire [3:0] conv_strobe,
   input wire [3:0] rx_valid,
   input wire rx_cd_oe,
   input wire gain_cd_oe,
   input wire probe_clk,
   input wire [5:0] probe_sig_sel
);
   // shadows assume full-word writes, which is all the bench issues
   wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   reg [2:0] ctl_ff;
   reg [23:0] prb_ff;
   reg [5:0] gap_ff;
   reg arm_ff;
   reg pclk_ff;
   always @(posedge clock) begin
      if (reset) begin
         ctl_ff <= 3'h0;
         prb_ff <= 24'h00_0000;
         arm_ff <= 1'b0;
      end else begin
         if (wr && wb_adr_i == `RTP_REG_CTRL)
            ctl_ff <= wb_dat_i[3:1];
         // a new rate leaves rate_ff running, so skip the first gap
         if (wr && wb_adr_i == `RTP_REG_PROBE) begin
            prb_ff <= wb_dat_i[23:0];
            arm_ff <= 1'b0;
         end else if (probe_clk && !pclk_ff)
            arm_ff <= 1'b1;
      end
      pclk_ff <= probe_clk;
      gap_ff <= (probe_clk && !pclk_ff) ? 6'h01 : gap_ff + 6'h01;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_fast;
      (ctl_ff == 3'h1) [*3];
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o) else $error("no ack");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_valid_strobe: assert property (
      !ctl_ff[0] && !$past(ctl_ff[0]) |-> rx_valid == $past(conv_strobe))
      else $error("valid not one cycle after strobe");
   a_bypass_full: assert property (s_fast |-> rx_valid == 4'hf)
      else $error("bypass rate 1 not every cycle");
   a_probe_oe: assert property (
      rx_cd_oe == prb_ff[0] && gain_cd_oe == prb_ff[0])
      else $error("probe output enable");
   a_sig_sel: assert property (probe_sig_sel == prb_ff[18:13])
      else $error("probe signal select");
   a_probe_period: assert property (
      $rose(probe_clk) && arm_ff && prb_ff[0]
      |-> gap_ff == {1'b0, prb_ff[23:19]} + 6'h01)
      else $error("probe clock period");
endmodule // rtp_checker

bind rtp_probe rtp_checker u_chk (.clock, .reset, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_strobe,
   .rx_valid, .rx_cd_oe, .gain_cd_oe, .probe_clk, .probe_sig_sel);

// File: verification/rtp_adc_model.sv
`timescale 1ns/1ps
module rtp_adc_model #(
   parameter DIV = 2
) (
   // system
   input wire clock,
   input wire reset,
   // converter side: a ramp, one step per strobe
   output reg [3:0] conv_strobe,
   output reg [63:0] rx_in
);
   reg [3:0] cnt_ff;
   always @(posedge clock) begin
      if (reset) begin
         cnt_ff <= 4'h0;
         conv_strobe <= 4'h0;
         rx_in <= 64'h0;
      end else begin
         cnt_ff <= (cnt_ff == DIV - 1) ? 4'h0 : cnt_ff + 4'h1;
         conv_strobe <= {4{cnt_ff == 4'h0}};
         // data moves on right after the strobe edge, no extra hold
         if (conv_strobe[0])
            rx_in <= rx_in + 64'h0001_0001_0001_0001;
      end
   end
endmodule // rtp_adc_model

// File: verification/testbench.sv
`timescale 1ns/1ps
`include "rtp_defs.vh"
module testbench;
   reg clock = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   reg [7:0] adr = 8'h0, sync_in = 8'h0;
   reg [31:0] wdat = 32'h0, rd;
   reg [15:0] last_wr = 16'h0;
   reg [323:0] src = {9{36'h9_a5c3_1e7f}};
   reg src_ramp = 1'b0;
   integer bad_count = 0, n_checks = 0, i, n;
   wire ack, cd_oe, g_oe, pclk, cpulse;
   wire [31:0] dat_o, cd_out;
   wire [3:0] strobe, valid;
   wire [63:0] rx_in, rx_out;
   wire [5:0] sig;
   wire [6:0] g_out;
   always #10 clock = ~clock;
   always @(posedge clock)
      if (strobe[0])
         last_wr <= rx_in[15:0];
   // receive-interface source counts up so every probe capture differs
   always @(posedge clock)
      if (src_ramp)
         src[8*36 +: 32] <= src[8*36 +: 32] + 32'h0000_0001;
   rtp_probe DUT (.clock(clock), .reset(reset), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .sync_in(sync_in),
      .conv_strobe(strobe), .rx_in(rx_in), .probe_src(src),
      .gain_cd_in(7'h0), .gain_cd_out(g_out), .gain_cd_oe(g_oe),
      .rx_cd_out(cd_out), .rx_cd_oe(cd_oe), .rx_out(rx_out),
      .rx_valid(valid), .probe_clk(pclk), .probe_sig_sel(sig),
      .counter_pulse(cpulse));
   rtp_adc_model mdl (.clock(clock), .reset(reset), .conv_strobe(strobe),
      .rx_in(rx_in));
   task chk(input [31:0] got, input [31:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d = 32'h0);
      integer t;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      t = 0;
      @(posedge clock);
      while (!ack && t < 64) begin
         @(posedge clock);
         t = t + 1;
      end
      if (ack !== 1'b1)
         bad_count = bad_count + 1;
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task pulse(input integer k);
      @(posedge clock);
      sync_in[k] <= 1'b1;
      @(posedge clock);
      sync_in[k] <= 1'b0;
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      bus(1, 8'h40, 32'hffff_ffff);
      bus(0, 8'h40);
      chk(rd, 32'h0);
      // noise on with a zero mask must leave the ramp untouched
      bus(1, `RTP_REG_CTRL, 32'h0000_0020);
      bus(1, `RTP_REG_DLYSEL, 32'h0000_0001);
      for (i = 5; i >= 0; i = i - 5) begin
         bus(1, `RTP_REG_DLY, i);
         bus(0, `RTP_REG_STATUS);
         chk(rd[13:8], 5 - i);
         pulse(1);
         bus(0, `RTP_REG_STATUS);
         chk(rd[13:8], i);
         repeat (140) @(posedge clock);
         repeat (4) begin
            @(posedge clock);
            while (!valid[0])
               @(posedge clock);
            chk(rx_out[15:0], last_wr - i - 1);
         end
      end
      for (i = 0; i < 4; i = i + 1) begin
         bus(1, `RTP_REG_CTRL, 32'h0000_0003 | i << 2);
         repeat (8) @(posedge clock);
         n = 0;
         repeat (64) @(posedge clock) n = n + valid[0];
         chk(n, 64 >> i);
      end
      bus(1, `RTP_REG_CONST, 32'h0002_a5f3);
      bus(1, `RTP_REG_CTRL, 32'h0000_0013);
      repeat (80) @(posedge clock);
      for (i = 0; i < 4; i = i + 1)
         chk(rx_out[16*i +: 16], 32'h0002_a5f3 >> 2);
      bus(1, `RTP_REG_CNT, 32'h0000_0014);
      bus(1, `RTP_REG_CNTCFG, 32'h0000_0200);
      pulse(2);
      while (!cpulse) @(posedge clock);
      n = 0;
      do begin
         @(posedge clock);
         n = n + 1;
      end while (!cpulse);
      chk(n == 20 || n == 21, 1'b1);
      bus(1, `RTP_REG_PROBE, 32'h0000_0001 | 32'h0000_002a << `RTP_PROBE_SIG
         | 32'h0000_0008 << `RTP_PROBE_SRC | 32'h0000_0003 << `RTP_PROBE_RATE);
      repeat (40) @(posedge clock);
      chk({cd_oe, g_oe}, 2'b11);
      chk(sig, 6'h2a);
      chk(cd_out, src[8*36 +: 32]);
      chk(g_out, {3'b000, src[8*36+32 +: 4]});
      // decimate by 17, aligned by sync_in[1], delay field 2, first capture four ticks after it
      bus(1, `RTP_REG_PROBE, 32'h0000_0007 | 32'h0000_0002 << `RTP_PROBE_DLY
         | 32'h0000_0008 << `RTP_PROBE_SRC);
      repeat (40) @(posedge clock);
      pulse(1);
      src_ramp <= 1'b1;
      rd = cd_out;
      n = 0;
      while (cd_out === rd && n < 64) begin
         @(posedge clock);
         n = n + 1;
      end
      chk(n, 5);
      n = 0;
      repeat (170) begin
         rd = cd_out;
         @(posedge clock);
         if (cd_out !== rd)
            n = n + 1;
      end
      chk(n, 10);
      bus(1, `RTP_REG_PROBE, 32'h0);
      chk(cd_oe, 1'b0);
      report_and_stop;
   end
   initial begin
      #400000;
      bad_count = bad_count + 1;
      report_and_stop;
   end
endmodule // testbench
